// ### src/sld_defines.svh
// constants of the serial-in latched driver: widths, reset values, timing counts
`ifndef SLD_DEFINES_SVH
`define SLD_DEFINES_SVH

// ----------------------------------------
// structure
// ----------------------------------------
`define SLD_STAGES 8
`define SLD_BUF_DEPTH 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define SLD_RST_BIT 1'b0
`define SLD_RST_WORD 8'h00

// ----------------------------------------
// timing, ns as printed, and derived cycle counts
// ----------------------------------------
`define SLD_MCLK_PERIOD_NS 10
`define SLD_T_SETUP_NS 75
`define SLD_T_HOLD_NS 75
`define SLD_T_CLK_WIDTH_NS 150
`define SLD_T_CLK_TO_STB_NS 300
`define SLD_T_STB_WIDTH_NS 100
// least times round up to whole cycles
`define SLD_CLK_TO_STB_CYC ((`SLD_T_CLK_TO_STB_NS + `SLD_MCLK_PERIOD_NS - 1) / `SLD_MCLK_PERIOD_NS)
`define SLD_STB_WIDTH_CYC ((`SLD_T_STB_WIDTH_NS + `SLD_MCLK_PERIOD_NS - 1) / `SLD_MCLK_PERIOD_NS)
`define SLD_CNT_W 6

`endif

// ### src/sld_pkg.sv
// types of the serial-in latched driver
package sld_pkg;

   // ----------------------------------------
   // shift progress since the last strobe
   // ----------------------------------------
   typedef enum logic [2:0] {
      SLD_ST_IDLE = 3'b001,
      SLD_ST_SHIFT = 3'b010,
      SLD_ST_FULL = 3'b100
   } sld_state_t;

endpackage

// ### src/sld_edge.sv
// rising and falling edge detector for a synchronous input level
`timescale 1ns/10ps
module sld_edge (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic level_in,
   output logic level_q,
   output logic rise,
   output logic fall
);
   logic prev_q;

   // ----------------------------------------
   // sample and previous value
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         level_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         level_q <= level_in;
         prev_q <= level_q;
      end
   end

   assign rise = level_q & ~prev_q;
   assign fall = ~level_q & prev_q;
endmodule // sld_edge

// ### src/sld_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module sld_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   // ----------------------------------------
   // parameter check
   // ----------------------------------------
   generate
      if (DEPTH != 2) begin : g_bad_depth
         $error("sld_buf supports a depth of two only");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [0:1];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] count_q;
   logic push;
   logic pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign in_ready = (count_q != 2'd2);
   assign out_valid = (count_q != 2'd0);
   assign out_data = mem_q[rd_ptr_q];

   // ----------------------------------------
   // storage and pointers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'd0;
      end else begin
         if (push) begin
            mem_q[wr_ptr_q] <= in_data;
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // sld_buf

// ### src/sld_top.sv
// serial-in latched driver: shift register, strobe latches, blanked outputs
`timescale 1ns/10ps
`include "sld_defines.svh"
module sld_top #(
   parameter int STAGES = `SLD_STAGES,
   parameter int BUF_DEPTH = `SLD_BUF_DEPTH
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ser_clk,
   input wire logic ser_in,
   input wire logic strobe,
   input wire logic out_en_blank,
   output logic ser_out,
   output logic [STAGES-1:0] drive_on,
   output logic word_valid,
   output logic [STAGES-1:0] word_data,
   input wire logic word_ready,
   output logic word_room,
   output logic frame_full,
   output logic strobe_short,
   output logic strobe_early,
   output sld_pkg::sld_state_t shift_state
);
   import sld_pkg::*;

   // ----------------------------------------
   // parameter check
   // ----------------------------------------
   generate
      if (STAGES < 2 || STAGES > 32) begin : g_bad_stages
         $error("sld_top needs between 2 and 32 stages");
      end
      // the drop warning on word_room assumes exactly two entries
      if (BUF_DEPTH != 2) begin : g_bad_depth
         $error("sld_top needs a two-entry word buffer");
      end
   endgenerate

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // saturating increment of a cycle counter
   function automatic logic [`SLD_CNT_W-1:0] sat_inc(input logic [`SLD_CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   localparam logic [`SLD_CNT_W-1:0] STB_MIN = `SLD_CNT_W'(`SLD_STB_WIDTH_CYC);
   localparam logic [`SLD_CNT_W-1:0] CLK_STB_MIN = `SLD_CNT_W'(`SLD_CLK_TO_STB_CYC);
   localparam logic [5:0] STAGES_W = 6'(STAGES);

   logic sclk_lvl;
   logic sclk_rise;
   logic stb_lvl;
   logic stb_rise;
   logic stb_fall;
   logic sdi_q;
   logic [STAGES-1:0] shift_q;
   logic [STAGES-1:0] shift_d;
   logic [STAGES-1:0] latch_q;
   logic [STAGES-1:0] latch_d;
   logic [STAGES-1:0] drive_q;
   logic [STAGES-1:0] drive_d;
   logic blank_q;
   logic [5:0] bits_q;
   logic [5:0] bits_d;
   sld_state_t state_q;
   sld_state_t state_d;
   logic [`SLD_CNT_W-1:0] stb_cnt_q;
   logic [`SLD_CNT_W-1:0] since_clk_q;
   logic strobe_short_q;
   logic strobe_early_q;
   logic [`SLD_CNT_W-1:0] stb_cnt_d;
   logic [`SLD_CNT_W-1:0] since_clk_d;
   logic strobe_short_d;
   logic strobe_early_d;
   logic push_valid;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [STAGES-1:0] buf_out_data;
   logic word_valid_q;
   logic [STAGES-1:0] word_data_q;
   logic word_room_q;
   logic hand_taken;

   // ----------------------------------------
   // input sampling
   // ----------------------------------------
   // data is delayed by one sample so it lines up with the clock edge detector
   sld_edge u_sclk_edge (
      .mclk(mclk),
      .rstn(rstn),
      .level_in(ser_clk),
      .level_q(sclk_lvl),
      .rise(sclk_rise),
      .fall()
   );

   sld_edge u_stb_edge (
      .mclk(mclk),
      .rstn(rstn),
      .level_in(strobe),
      .level_q(stb_lvl),
      .rise(stb_rise),
      .fall(stb_fall)
   );

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sdi_q <= `SLD_RST_BIT;
         blank_q <= 1'b1;
      end else begin
         sdi_q <= ser_in;
         blank_q <= out_en_blank;
      end
   end

   // ----------------------------------------
   // shift register
   // ----------------------------------------
   // stage 0 is the entry, stage STAGES-1 feeds the serial output
   assign shift_d = sclk_rise ? {shift_q[STAGES-2:0], sdi_q} : shift_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         shift_q <= '0;
      end else begin
         shift_q <= shift_d;
      end
   end

   // last stage is itself a flop, so the cascade pin moves only after a shift
   assign ser_out = shift_q[STAGES-1];

   // ----------------------------------------
   // output latches
   // ----------------------------------------
   // transparent: the latch follows the register one sample behind
   assign latch_d = stb_lvl ? shift_q : latch_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         latch_q <= STAGES'(`SLD_RST_WORD);
      end else begin
         latch_q <= latch_d;
      end
   end

   // ----------------------------------------
   // output drivers
   // ----------------------------------------
   // strobe tied high with blanking low shows shifting data on the loads
   assign drive_d = blank_q ? '0 : latch_d;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         drive_q <= '0;
      end else begin
         drive_q <= drive_d;
      end
   end

   assign drive_on = drive_q;

   // ----------------------------------------
   // shift progress
   // ----------------------------------------
   always_comb begin
      bits_d = bits_q;
      state_d = state_q;
      if (stb_lvl) begin
         bits_d = 6'd0;
      end else if (sclk_rise && bits_q != STAGES_W) begin
         bits_d = bits_q + 6'd1;
      end
      case (state_q)
         SLD_ST_IDLE: begin
            if (!stb_lvl && sclk_rise) begin
               state_d = (STAGES_W == 6'd1) ? SLD_ST_FULL : SLD_ST_SHIFT;
            end
         end
         SLD_ST_SHIFT: begin
            if (stb_lvl) begin
               state_d = SLD_ST_IDLE;
            end else if (bits_d == STAGES_W) begin
               state_d = SLD_ST_FULL;
            end
         end
         SLD_ST_FULL: begin
            if (stb_lvl) begin
               state_d = SLD_ST_IDLE;
            end
         end
         default: begin
            state_d = SLD_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bits_q <= 6'd0;
         state_q <= SLD_ST_IDLE;
      end else begin
         bits_q <= bits_d;
         state_q <= state_d;
      end
   end

   assign shift_state = state_q;
   assign frame_full = state_q[2];

   // ----------------------------------------
   // strobe timing checks
   // ----------------------------------------
   // checks only report; the latches still act, as the real part would
   assign stb_cnt_d = stb_rise ? `SLD_CNT_W'(1) : (stb_lvl ? sat_inc(stb_cnt_q) : stb_cnt_q);
   assign since_clk_d = sclk_rise ? '0 : sat_inc(since_clk_q);
   assign strobe_short_d = stb_fall && (stb_cnt_q < STB_MIN);
   assign strobe_early_d = stb_rise && (since_clk_q < CLK_STB_MIN);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stb_cnt_q <= '0;
         since_clk_q <= '1;
         strobe_short_q <= 1'b0;
         strobe_early_q <= 1'b0;
      end else begin
         stb_cnt_q <= stb_cnt_d;
         since_clk_q <= since_clk_d;
         strobe_short_q <= strobe_short_d;
         strobe_early_q <= strobe_early_d;
      end
   end

   assign strobe_short = strobe_short_q;
   assign strobe_early = strobe_early_q;

   // ----------------------------------------
   // captured word stream
   // ----------------------------------------
   // each closing strobe pushes the held word; a full buffer drops it
   // and word_room warns the controller before that happens
   assign push_valid = stb_fall;

   sld_buf #(
      .WIDTH(STAGES),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .mclk(mclk),
      .rstn(rstn),
      .in_valid(push_valid),
      .in_data(latch_q),
      .in_ready(buf_in_ready),
      .out_valid(buf_out_valid),
      .out_data(buf_out_data),
      .out_ready(hand_taken)
   );

   // output stage registers the buffer head; taken when empty or accepted
   assign hand_taken = buf_out_valid && (!word_valid_q || word_ready);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         word_valid_q <= 1'b0;
         word_data_q <= '0;
         word_room_q <= 1'b0;
      end else begin
         if (hand_taken) begin
            word_valid_q <= 1'b1;
            word_data_q <= buf_out_data;
         end else if (word_ready) begin
            word_valid_q <= 1'b0;
         end
         word_room_q <= buf_in_ready;
      end
   end

   assign word_valid = word_valid_q;
   assign word_data = word_data_q;
   assign word_room = word_room_q;
endmodule // sld_top

// ### dv/sld_props.sv
// port checker for the serial-in latched driver
`timescale 1ns/10ps
module sld_props #(
   parameter int STAGES = 8
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ser_clk,
   input wire logic ser_in,
   input wire logic strobe,
   input wire logic out_en_blank,
   input wire logic ser_out,
   input wire logic [STAGES-1:0] drive_on,
   input wire logic word_valid,
   input wire logic [STAGES-1:0] word_data,
   input wire logic word_ready,
   input wire logic word_room,
   input wire logic frame_full,
   input wire logic strobe_short,
   input wire logic strobe_early,
   input wire sld_pkg::sld_state_t shift_state
);
   import sld_pkg::*;
   // ---
   // input history, a window wide enough for one cycle of lag either way
   // ---
   logic [3:0] sc_q, stb_q, blk_q, so_q;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sc_q <= '0;
         stb_q <= '0;
         blk_q <= '0;
         so_q <= '0;
      end else begin
         sc_q <= {sc_q[2:0], ser_clk};
         stb_q <= {stb_q[2:0], strobe};
         blk_q <= {blk_q[2:0], out_en_blank};
         so_q <= {so_q[2:0], ser_out};
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   ser_hold_a: assert property (!(|(sc_q[2:0] & ~sc_q[3:1])) |-> $stable(ser_out))
      else $error("serial output moved without a clock rise");
   blank_off_a: assert property (blk_q[2:0] == 3'b111 |-> drive_on == '0)
      else $error("output on while blanked");
   latch_hold_a: assert property (stb_q[2:0] == 3'b000 && blk_q == 4'h0 |-> $stable(drive_on))
      else $error("latch changed with strobe low");
   latch_follow_a: assert property (stb_q[2:0] == 3'b111 && blk_q[2:0] == 3'b000 &&
         (so_q[2:0] == 3'b000 || so_q[2:0] == 3'b111) |-> drive_on[STAGES-1] == so_q[0])
      else $error("latch not following last stage");
   word_keep_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
      else $error("word dropped before acceptance");
   state_hot_a: assert property ($onehot(shift_state))
      else $error("shift state not one-hot");
   short_pulse_a: assert property (strobe_short |=> !strobe_short)
      else $error("short strobe flag wider than one cycle");
   early_pulse_a: assert property (strobe_early |=> !strobe_early)
      else $error("early strobe flag wider than one cycle");
endmodule // sld_props

bind sld_top sld_props #(.STAGES(STAGES)) sld_props_inst (
   .mclk(mclk), .rstn(rstn), .ser_clk(ser_clk), .ser_in(ser_in), .strobe(strobe),
   .out_en_blank(out_en_blank), .ser_out(ser_out), .drive_on(drive_on), .word_valid(word_valid),
   .word_data(word_data), .word_ready(word_ready), .word_room(word_room), .frame_full(frame_full),
   .strobe_short(strobe_short), .strobe_early(strobe_early), .shift_state(shift_state)
);

// ### dv/sld_ctrl.sv
// controller model: serial clock and data, strobe and blanking
`timescale 1ns/10ps
module sld_ctrl (
   input wire logic mclk,
   output logic ser_clk,
   output logic ser_in,
   output logic strobe,
   output logic out_en_blank
);
   initial begin
      ser_clk = 1'b0;
      ser_in = 1'b0;
      strobe = 1'b0;
      out_en_blank = 1'b0;
   end
   // ---
   // msb first; hold sets both clock phases
   // ---
   task automatic shift_bits(input logic [7:0] w, input int n, input int hold);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge mclk);
         #1 ser_in = w[i];
         repeat (hold) @(posedge mclk);
         #1 ser_clk = 1'b1;
         repeat (hold) @(posedge mclk);
         #1 ser_clk = 1'b0;
         ser_in = ~w[i]; // hold over, so no stale bit looks valid
      end
   endtask
   task automatic pulse_strobe(input int len);
      @(posedge mclk);
      #1 strobe = 1'b1;
      repeat (len) @(posedge mclk);
      #1 strobe = 1'b0;
   endtask
   task automatic set_level(input logic stb, input logic blank);
      @(posedge mclk);
      #1 strobe = stb;
      out_en_blank = blank;
   endtask
endmodule // sld_ctrl

// ### dv/tb.sv
// self-checking bench for the serial-in latched driver
`timescale 1ns/10ps
module tb;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic word_ready = 1'b1;
   logic ser_clk, ser_in, strobe, out_en_blank, ser_out, word_valid;
   logic word_room, frame_full, strobe_short, strobe_early;
   logic [7:0] drive_on, word_data;
   sld_pkg::sld_state_t shift_state;
   int error_cnt = 0;
   int checks = 0;
   int short_cnt = 0;
   int early_cnt = 0;
   always #5 mclk = ~mclk;
   // one-cycle flags are counted here so the tasks can judge them later
   always @(posedge mclk) begin
      if (strobe_short === 1'b1) short_cnt++;
      if (strobe_early === 1'b1) early_cnt++;
   end
   sld_ctrl sld_ctrl_inst (.mclk(mclk), .ser_clk(ser_clk), .ser_in(ser_in), .strobe(strobe),
      .out_en_blank(out_en_blank));
   sld_top sld_top_inst (.mclk(mclk), .rstn(rstn), .ser_clk(ser_clk), .ser_in(ser_in), .strobe(strobe),
      .out_en_blank(out_en_blank), .ser_out(ser_out), .drive_on(drive_on), .word_valid(word_valid),
      .word_data(word_data), .word_ready(word_ready), .word_room(word_room), .frame_full(frame_full),
      .strobe_short(strobe_short), .strobe_early(strobe_early), .shift_state(shift_state));
   task automatic test_done();
      if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic settle();
      repeat (4) @(posedge mclk);
      #1;
   endtask
   task automatic take_word(input logic [7:0] exp);
      int n;
      n = 0;
      while (word_valid !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1 n++;
      end
      chk(word_data, exp, "word");
      word_ready = 1'b1;
      @(posedge mclk);
      #1 word_ready = 1'b0;
   endtask
   task automatic t_load();
      int e0;
      int s0;
      e0 = early_cnt;
      s0 = short_cnt;
      word_ready = 1'b0;
      sld_ctrl_inst.shift_bits(8'hA5, 8, 2);
      chk({7'h0, frame_full}, 8'h01, "full frame");
      sld_ctrl_inst.pulse_strobe(10);
      settle();
      chk(drive_on, 8'hA5, "parallel");
      chk(8'(early_cnt - e0), 8'h01, "early strobe");
      chk(8'(short_cnt - s0), 8'h00, "short strobe");
      chk({5'h0, shift_state}, {5'h0, sld_pkg::SLD_ST_IDLE}, "idle state");
      chk({7'h0, ser_out}, 8'h01, "cascade");
      take_word(8'hA5);
   endtask
   task automatic t_hold();
      sld_ctrl_inst.shift_bits(8'h5C, 8, 2);
      settle();
      chk(drive_on, 8'hA5, "held");
      chk({5'h0, shift_state}, {5'h0, sld_pkg::SLD_ST_FULL}, "full state");
      chk({7'h0, ser_out}, 8'h00, "msb out");
      sld_ctrl_inst.shift_bits(8'h01, 1, 2);
      settle();
      chk({7'h0, ser_out}, 8'h01, "next out");
      sld_ctrl_inst.pulse_strobe(10);
      settle();
      chk(drive_on, 8'hB9, "shifted");
      take_word(8'hB9);
   endtask
   task automatic t_blank();
      sld_ctrl_inst.set_level(1'b0, 1'b1);
      settle();
      chk(drive_on, 8'h00, "blanked");
      sld_ctrl_inst.shift_bits(8'h3C, 8, 2);
      sld_ctrl_inst.set_level(1'b0, 1'b0);
      settle();
      chk(drive_on, 8'hB9, "unblanked");
      chk({7'h0, ser_out}, 8'h00, "kept shifting");
   endtask
   task automatic t_transparent();
      int e0;
      int s0;
      e0 = early_cnt;
      s0 = short_cnt;
      // strobe rises long after the last shift, so no early flag
      repeat (40) @(posedge mclk);
      sld_ctrl_inst.set_level(1'b1, 1'b1);
      sld_ctrl_inst.shift_bits(8'h96, 8, 2);
      settle();
      chk(drive_on, 8'h00, "blank in entry");
      chk({7'h0, frame_full}, 8'h00, "no frame while open");
      sld_ctrl_inst.set_level(1'b1, 1'b0);
      settle();
      chk(drive_on, 8'h96, "transparent");
      sld_ctrl_inst.set_level(1'b0, 1'b0);
      take_word(8'h96);
      chk(8'(early_cnt - e0), 8'h00, "late strobe");
      chk(8'(short_cnt - s0), 8'h00, "long strobe");
   endtask
   task automatic t_buffer();
      int e0;
      int s0;
      e0 = early_cnt;
      s0 = short_cnt;
      // output stage plus two entries hold three words; the fourth is dropped
      for (int i = 1; i <= 4; i++) begin
         sld_ctrl_inst.shift_bits(8'(8'h11 * i), 8, 2);
         sld_ctrl_inst.pulse_strobe(3);
      end
      settle();
      chk({7'h0, word_room}, 8'h00, "full");
      chk(8'(short_cnt - s0), 8'h04, "short strobes");
      chk(8'(early_cnt - e0), 8'h04, "early strobes");
      take_word(8'h11);
      take_word(8'h22);
      take_word(8'h33);
      settle();
      chk({7'h0, word_valid}, 8'h00, "empty");
      sld_ctrl_inst.shift_bits(8'h01, 1, 2);
      settle();
      chk({5'h0, shift_state}, {5'h0, sld_pkg::SLD_ST_SHIFT}, "partial frame");
      chk({7'h0, frame_full}, 8'h00, "frame not full");
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      #1 rstn = 1'b1;
      t_load();
      t_hold();
      t_blank();
      t_transparent();
      t_buffer();
      test_done();
   end
   // whole run is near 470 cycles
   initial begin
      #50000;
      error_cnt++;
      test_done();
   end
endmodule // tb
